// file: hdl/cbsc_exec.v
// execute unit: carry bit ops, branches, call/return, push/pop, irq enables, ports, halt/stop
// assumes a fetcher presenting one decoded op at a time and a data memory with 1-cycle read latency
// Operation
// - or-carry sets carry to carry OR bit
// - xor-carry sets carry to carry XOR bit
// - relative branch -15..-1, +2..+16, no boundaries
// - block branch loads all 11 pc bits
// - far call stacks pc in four nibbles
// - far call target limited to 000..77f
// - return reloads pc, sp plus four
// - skipping return also skips next instruction
// - interrupt return also restores status word
// - push stores high then low, sp minus two
// - pop loads low then high, sp plus two
// - enable-all sets master irq enable
// - disable-all clears master irq enable
// - per-source enable set or clear, four sources
// - port input only from ports 0-3,5,6
// - port read: latch if output, pins otherwise
// - port output only to ports 2,3,5,6
// - halt sets clock control bit 2
// - stop sets clock control bit 3
// - op after halt or stop is nop
// - nop takes one cycle, changes nothing
`include "cbsc_defs.vh"
module cbsc_exec (
  input wire clk,
  input wire rst_b,
  input wire op_valid,
  output wire op_ready,
  input wire [4:0] op_code,
  input wire [10:0] op_imm,
  input wire [1:0] op_len,
  input wire [7:0] bit_addr,
  input wire [1:0] bit_sel,
  output reg op_done_reg,
  output reg op_fault_reg,
  output wire [10:0] pc,
  output wire [7:0] sp,
  output wire [3:0] acc_a,
  output wire [3:0] acc_x,
  output wire [3:0] ptr_h,
  output wire [3:0] ptr_l,
  output wire [7:0] program_status_word,
  output wire carry_flag,
  output wire master_irq_enable,
  output wire [3:0] source_irq_enable,
  output wire [3:0] proc_clock_ctrl,
  input wire clock_wake,
  output reg [7:0] mem_addr,
  output reg [3:0] mem_wdata,
  output reg mem_we,
  output reg mem_re,
  input wire [3:0] mem_rdata,
  input wire [27:0] port_pin_in,
  input wire [6:0] port_out_mode,
  output wire [27:0] port_out
);
  localparam ST_IDLE = 2'b00;
  localparam ST_RD = 2'b01;
  localparam ST_WR = 2'b10;
  localparam ST_FIN = 2'b11;

  reg [1:0] state_reg;
  reg [2:0] step_reg;
  reg [4:0] op_reg;
  reg [10:0] imm_reg;
  reg [10:0] pc_reg;
  reg [7:0] sp_reg;
  reg [3:0] a_reg;
  reg [3:0] x_reg;
  reg [3:0] h_reg;
  reg [3:0] l_reg;
  reg [7:0] psw_reg;
  reg ime_reg;
  reg [3:0] ie_reg;
  reg [3:0] pcc_reg;
  reg nop_next_reg;
  reg [3:0] rd_buf [0:4];
  reg [2:0] n_steps;
  reg [7:0] off;
  reg fetched_bit;
  wire [3:0] port_rd;
  wire take;
  wire port_in_ok;
  wire port_out_ok;
  wire rel_ok;
  wire signed [5:0] rel_off;
  wire [10:0] pc_next_seq;
  wire [10:0] rel_target;

  assign op_ready = (state_reg == ST_IDLE);
  assign take = op_valid && op_ready;
  assign pc = pc_reg;
  assign sp = sp_reg;
  assign acc_a = a_reg;
  assign acc_x = x_reg;
  assign ptr_h = h_reg;
  assign ptr_l = l_reg;
  assign program_status_word = psw_reg;
  assign carry_flag = psw_reg[`CBSC_PSW_CY];
  assign master_irq_enable = ime_reg;
  assign source_irq_enable = ie_reg;
  assign proc_clock_ctrl = pcc_reg;
  assign pc_next_seq = pc_reg + {9'h000, op_len};
  assign rel_off = op_imm[5:0];
  // target counts from the branch's own address, wrapping across pages and blocks
  assign rel_target = pc_reg + {{5{rel_off[5]}}, rel_off};
  assign rel_ok = (rel_off >= `CBSC_REL_MIN && rel_off <= `CBSC_REL_NEG_MAX)
    || (rel_off >= `CBSC_REL_POS_MIN && rel_off <= `CBSC_REL_MAX);
  assign port_in_ok = (op_imm[3:0] <= 4'h3) || (op_imm[3:0] == 4'h5) || (op_imm[3:0] == 4'h6);
  assign port_out_ok = (op_imm[3:0] == 4'h2) || (op_imm[3:0] == 4'h3)
    || (op_imm[3:0] == 4'h5) || (op_imm[3:0] == 4'h6);

  cbsc_port_bank u_ports (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(take && !nop_next_reg && op_code == `CBSC_OP_OUT && port_out_ok),
    .sel(op_imm[3:0]),
    .wdata(a_reg),
    .pin_in(port_pin_in),
    .out_mode(port_out_mode),
    .port_out(port_out),
    .rd_data(port_rd)
  );

  // step counts and stack offsets for each sequenced op
  always @*
  begin
    n_steps = 3'd0;
    off = 8'h00;
    case (op_reg)
      `CBSC_OP_OR1, `CBSC_OP_XOR_CARRY_BIT_OP: n_steps = 3'd1;
      `CBSC_OP_FAR_CALL_OP:
      begin
        n_steps = 3'd4;
        off = 8'hff - {5'h00, step_reg};
      end
      `CBSC_OP_PUSH:
      begin
        n_steps = 3'd2;
        off = 8'hff - {5'h00, step_reg};
      end
      `CBSC_OP_RET, `CBSC_OP_SKIPPING_RETURN_OP, `CBSC_OP_INTERRUPT_RETURN_OP:
      begin
        n_steps = (op_reg == `CBSC_OP_INTERRUPT_RETURN_OP) ? 3'd5 : 3'd3;
        off = (step_reg == 3'd0) ? 8'h00 : {5'h00, step_reg} + 8'h01;
      end
      `CBSC_OP_POP:
      begin
        n_steps = 3'd2;
        off = {5'h00, step_reg};
      end
      default: n_steps = 3'd0;
    endcase
  end

  // memory strobes follow the sequencer state
  always @*
  begin
    mem_addr = 8'h00;
    mem_wdata = `CBSC_NIB_RST;
    mem_we = 1'b0;
    mem_re = 1'b0;
    fetched_bit = mem_rdata[bit_sel];
    if (state_reg == ST_RD && step_reg < n_steps)
    begin
      mem_re = 1'b1;
      mem_addr = (op_reg == `CBSC_OP_OR1 || op_reg == `CBSC_OP_XOR_CARRY_BIT_OP) ? bit_addr : sp_reg + off;
    end
    else if (state_reg == ST_WR)
    begin
      mem_we = 1'b1;
      mem_addr = sp_reg + off;
      if (op_reg == `CBSC_OP_FAR_CALL_OP)
      begin
        case (step_reg)
          3'd0: mem_wdata = pc_reg[7:4];
          3'd1: mem_wdata = pc_reg[3:0];
          3'd2: mem_wdata = 4'h0;
          default: mem_wdata = {1'b0, pc_reg[10:8]};
        endcase
      end
      else if (imm_reg[0])
        mem_wdata = (step_reg == 3'd0) ? h_reg : l_reg;
      else
        mem_wdata = (step_reg == 3'd0) ? x_reg : a_reg;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_reg <= ST_IDLE;
      step_reg <= 3'd0;
      op_reg <= `CBSC_OP_NOP;
      imm_reg <= 11'h000;
      pc_reg <= `CBSC_PC_RST;
      sp_reg <= `CBSC_SP_RST;
      a_reg <= `CBSC_NIB_RST;
      x_reg <= `CBSC_NIB_RST;
      h_reg <= `CBSC_NIB_RST;
      l_reg <= `CBSC_NIB_RST;
      psw_reg <= `CBSC_PSW_RST;
      ime_reg <= 1'b0;
      ie_reg <= `CBSC_NIB_RST;
      pcc_reg <= `CBSC_NIB_RST;
      nop_next_reg <= 1'b0;
      op_done_reg <= 1'b0;
      op_fault_reg <= 1'b0;
    end
    else
    begin
      op_done_reg <= 1'b0;
      op_fault_reg <= 1'b0;
      // wake clears the mode bits; a halt or stop in the same cycle wins
      if (clock_wake)
        pcc_reg[`CBSC_PCC_STOP:`CBSC_PCC_HALT] <= 2'b00;
      case (state_reg)
        ST_IDLE:
        begin
          if (take)
          begin
            op_reg <= op_code;
            imm_reg <= op_imm;
            step_reg <= 3'd0;
            pc_reg <= pc_next_seq;
            if (nop_next_reg)
            begin
              nop_next_reg <= 1'b0;
              op_done_reg <= 1'b1;
            end
            else
            begin
              op_done_reg <= 1'b1;
              case (op_code)
                `CBSC_OP_OR1, `CBSC_OP_XOR_CARRY_BIT_OP, `CBSC_OP_RET, `CBSC_OP_SKIPPING_RETURN_OP, `CBSC_OP_INTERRUPT_RETURN_OP, `CBSC_OP_POP:
                begin
                  state_reg <= ST_RD;
                  op_done_reg <= 1'b0;
                end
                `CBSC_OP_PUSH:
                begin
                  state_reg <= ST_WR;
                  op_done_reg <= 1'b0;
                end
                `CBSC_OP_FAR_CALL_OP:
                begin
                  if (op_imm <= `CBSC_ADDR_MAX)
                  begin
                    state_reg <= ST_WR;
                    op_done_reg <= 1'b0;
                  end
                  else
                    op_fault_reg <= 1'b1;
                end
                `CBSC_OP_BRREL:
                begin
                  if (rel_ok)
                    pc_reg <= rel_target;
                  else
                    op_fault_reg <= 1'b1;
                end
                `CBSC_OP_BLOCK_ABSOLUTE_BRANCH:
                begin
                  if (op_imm <= `CBSC_ADDR_MAX)
                    pc_reg <= op_imm;
                  else
                    op_fault_reg <= 1'b1;
                end
                `CBSC_OP_EI: ime_reg <= 1'b1;
                `CBSC_OP_DI: ime_reg <= 1'b0;
                `CBSC_OP_EISRC: ie_reg[op_imm[1:0]] <= 1'b1;
                `CBSC_OP_DISRC: ie_reg[op_imm[1:0]] <= 1'b0;
                `CBSC_OP_IN:
                begin
                  if (port_in_ok)
                    a_reg <= port_rd;
                  else
                    op_fault_reg <= 1'b1;
                end
                `CBSC_OP_OUT:
                begin
                  if (!port_out_ok)
                    op_fault_reg <= 1'b1;
                end
                `CBSC_OP_HALT:
                begin
                  pcc_reg[`CBSC_PCC_HALT] <= 1'b1;
                  nop_next_reg <= 1'b1;
                end
                `CBSC_OP_STOP:
                begin
                  pcc_reg[`CBSC_PCC_STOP] <= 1'b1;
                  nop_next_reg <= 1'b1;
                end
                `CBSC_OP_NOP: op_done_reg <= 1'b1;
                default: op_fault_reg <= 1'b1;
              endcase
            end
          end
        end
        ST_RD:
        begin
          // read data lags its address by one cycle
          if (step_reg != 3'd0)
            rd_buf[step_reg - 3'd1] <= mem_rdata;
          if (step_reg == n_steps)
          begin
            state_reg <= ST_FIN;
            if (op_reg == `CBSC_OP_OR1)
              psw_reg[`CBSC_PSW_CY] <= psw_reg[`CBSC_PSW_CY] | fetched_bit;
            else if (op_reg == `CBSC_OP_XOR_CARRY_BIT_OP)
              psw_reg[`CBSC_PSW_CY] <= psw_reg[`CBSC_PSW_CY] ^ fetched_bit;
          end
          else
            step_reg <= step_reg + 3'd1;
        end
        ST_WR:
        begin
          if (step_reg == n_steps - 3'd1)
            state_reg <= ST_FIN;
          else
            step_reg <= step_reg + 3'd1;
        end
        ST_FIN:
        begin
          state_reg <= ST_IDLE;
          op_done_reg <= 1'b1;
          case (op_reg)
            `CBSC_OP_FAR_CALL_OP:
            begin
              sp_reg <= sp_reg - 8'h04;
              pc_reg <= imm_reg;
            end
            `CBSC_OP_PUSH: sp_reg <= sp_reg - 8'h02;
            `CBSC_OP_POP:
            begin
              sp_reg <= sp_reg + 8'h02;
              if (imm_reg[0])
              begin
                l_reg <= rd_buf[0];
                h_reg <= rd_buf[1];
              end
              else
              begin
                a_reg <= rd_buf[0];
                x_reg <= rd_buf[1];
              end
            end
            `CBSC_OP_RET, `CBSC_OP_SKIPPING_RETURN_OP, `CBSC_OP_INTERRUPT_RETURN_OP:
            begin
              pc_reg <= {rd_buf[0][2:0], rd_buf[2], rd_buf[1]};
              if (op_reg == `CBSC_OP_INTERRUPT_RETURN_OP)
              begin
                psw_reg <= {rd_buf[4], rd_buf[3]};
                sp_reg <= sp_reg + 8'h06;
              end
              else
                sp_reg <= sp_reg + 8'h04;
              if (op_reg == `CBSC_OP_SKIPPING_RETURN_OP)
                nop_next_reg <= 1'b1;
            end
            default: sp_reg <= sp_reg;
          endcase
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule

// file: include/cbsc_defs.vh
// constants for the branch, stack and control execute unit
// assumes one clock domain and a 4-bit wide data memory holding the stack
`ifndef CBSC_DEFS_VH
`define CBSC_DEFS_VH
// operation codes presented on op_code
`define CBSC_OP_NOP 5'h00
`define CBSC_OP_OR1 5'h01
`define CBSC_OP_XOR_CARRY_BIT_OP 5'h02
`define CBSC_OP_BRREL 5'h03
`define CBSC_OP_BLOCK_ABSOLUTE_BRANCH 5'h04
`define CBSC_OP_FAR_CALL_OP 5'h05
`define CBSC_OP_RET 5'h06
`define CBSC_OP_SKIPPING_RETURN_OP 5'h07
`define CBSC_OP_INTERRUPT_RETURN_OP 5'h08
`define CBSC_OP_PUSH 5'h09
`define CBSC_OP_POP 5'h0a
`define CBSC_OP_EI 5'h0b
`define CBSC_OP_DI 5'h0c
`define CBSC_OP_EISRC 5'h0d
`define CBSC_OP_DISRC 5'h0e
`define CBSC_OP_IN 5'h0f
`define CBSC_OP_OUT 5'h10
`define CBSC_OP_HALT 5'h11
`define CBSC_OP_STOP 5'h12
// absolute and call target ceiling
`define CBSC_ADDR_MAX 11'h77f
// relative branch reach
`define CBSC_REL_MIN (-6'sd15)
`define CBSC_REL_NEG_MAX (-6'sd1)
`define CBSC_REL_POS_MIN 6'sd2
`define CBSC_REL_MAX 6'sd16
// field positions
`define CBSC_PSW_CY 7
`define CBSC_PCC_HALT 2
`define CBSC_PCC_STOP 3
`define CBSC_IE_BT 0
`define CBSC_IE_CSI 1
`define CBSC_IE_EXT0 2
`define CBSC_IE_EXT2 3
// reset values
`define CBSC_PC_RST 11'h000
`define CBSC_SP_RST 8'h00
`define CBSC_PSW_RST 8'h00
`define CBSC_NIB_RST 4'h0
// port count
`define CBSC_PORTS 7
`endif

// file: hdl/cbsc_port_bank.v
// port latches and pin sampling for the execute unit
// assumes pins are asynchronous to clk; 4 bits per port, ports 0..6
`include "cbsc_defs.vh"
module cbsc_port_bank (
  input wire clk,
  input wire rst_b,
  input wire wr_en,
  input wire [3:0] sel,
  input wire [3:0] wdata,
  input wire [27:0] pin_in,
  input wire [6:0] out_mode,
  output wire [27:0] port_out,
  output reg [3:0] rd_data
);
  wire [27:0] pin_stable;
  genvar i;
  generate
    for (i = 0; i < `CBSC_PORTS; i = i + 1)
    begin : g_port
      reg [3:0] s1_reg;
      reg [3:0] s2_reg;
      reg [3:0] s3_reg;
      reg [3:0] stable_reg;
      always @(posedge clk)
      begin
        if (!rst_b)
        begin
          s1_reg <= `CBSC_NIB_RST;
          s2_reg <= `CBSC_NIB_RST;
          s3_reg <= `CBSC_NIB_RST;
          stable_reg <= `CBSC_NIB_RST;
        end
        else
        begin
          s1_reg <= pin_in[4*i+3:4*i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          // filter: a change counts once two samples agree
          if (s2_reg == s3_reg)
            stable_reg <= s3_reg;
        end
      end
      assign pin_stable[4*i+3:4*i] = stable_reg;
      if (i == 2 || i == 3 || i == 5 || i == 6)
      begin : g_latch
        reg [3:0] latch_reg;
        always @(posedge clk)
        begin
          if (!rst_b)
            latch_reg <= `CBSC_NIB_RST;
          else if (wr_en && sel == i)
            latch_reg <= wdata;
        end
        assign port_out[4*i+3:4*i] = latch_reg;
      end
      else
      begin : g_in_only
        // port 0, 1 or 4: no latch to drive
        assign port_out[4*i+3:4*i] = `CBSC_NIB_RST;
      end
    end
  endgenerate

  always @*
  begin
    rd_data = `CBSC_NIB_RST;
    case (sel)
      4'h0: rd_data = pin_stable[3:0];
      4'h1: rd_data = pin_stable[7:4];
      4'h2: rd_data = out_mode[2] ? port_out[11:8] : pin_stable[11:8];
      4'h3: rd_data = out_mode[3] ? port_out[15:12] : pin_stable[15:12];
      4'h4: rd_data = `CBSC_NIB_RST;
      4'h5: rd_data = out_mode[5] ? port_out[23:20] : pin_stable[23:20];
      4'h6: rd_data = out_mode[6] ? port_out[27:24] : pin_stable[27:24];
      default: rd_data = `CBSC_NIB_RST;
    endcase
  end
endmodule

// file: bench/cbsc_checker.sv
// concurrent checks on the execute unit's op port, stack strobes and flags
// assumes binding to cbsc_exec; one clock, synchronous active-low reset
`include "cbsc_defs.vh"
module cbsc_checker (
  input wire clk,
  input wire rst_b,
  input wire op_valid,
  input wire op_ready,
  input wire [4:0] op_code,
  input wire [10:0] op_imm,
  input wire [1:0] op_len,
  input wire op_done_reg,
  input wire op_fault_reg,
  input wire [10:0] pc,
  input wire [7:0] sp,
  input wire master_irq_enable,
  input wire [3:0] proc_clock_ctrl,
  input wire [7:0] mem_addr,
  input wire mem_we
);
  timeunit 1ns;
  timeprecision 1ns;
  wire tk = op_valid && op_ready;
  // op taken right after halt, stop or skipping return is a nop
  reg skip_reg;
  wire g = tk && !skip_reg;
  always @(posedge clk)
    if (!rst_b)
      skip_reg <= 1'b0;
    else if (tk)
      // a skipped op never arms a further skip, whatever its code
      skip_reg <= !skip_reg && (op_code == `CBSC_OP_HALT || op_code == `CBSC_OP_STOP
        || op_code == `CBSC_OP_SKIPPING_RETURN_OP);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_nop_one_cycle: assert property (g && op_code == `CBSC_OP_NOP |-> ##1 op_done_reg && !op_fault_reg)
    else $error("nop not done in one cycle");
  a_skip_acts_nop: assert property (tk && skip_reg |-> ##1 op_done_reg && !op_fault_reg
    && pc == $past(pc) + $past(op_len) && $stable(master_irq_enable)) else $error("skipped op acted");
  a_halt_sets_bit: assert property (g && op_code == `CBSC_OP_HALT |-> ##1 proc_clock_ctrl[2])
    else $error("halt bit not set");
  a_stop_sets_bit: assert property (g && op_code == `CBSC_OP_STOP |-> ##1 proc_clock_ctrl[3])
    else $error("stop bit not set");
  a_ei_sets_master: assert property (g && op_code == `CBSC_OP_EI |-> ##1 master_irq_enable)
    else $error("master enable not set");
  a_di_clears_master: assert property (g && op_code == `CBSC_OP_DI |-> ##1 !master_irq_enable)
    else $error("master enable not cleared");
  a_push_order: assert property (g && op_code == `CBSC_OP_PUSH |-> ##1 mem_we && mem_addr == sp - 8'h01
    ##1 mem_we && mem_addr == sp - 8'h02 ##2 op_done_reg && sp == $past(sp, 4) - 8'h02) else $error("push order");
  a_block_absolute_branch_loads_pc: assert property (g && op_code == `CBSC_OP_BLOCK_ABSOLUTE_BRANCH && op_imm <= 11'h77f |-> ##1 pc == $past(op_imm))
    else $error("block branch target");
  a_far_limit: assert property (g && op_code inside {`CBSC_OP_BLOCK_ABSOLUTE_BRANCH, `CBSC_OP_FAR_CALL_OP} && op_imm > 11'h77f
    |-> ##1 op_fault_reg && op_done_reg) else $error("target above limit taken");
  a_call_frame: assert property (g && op_code == `CBSC_OP_FAR_CALL_OP && op_imm <= 11'h77f |-> ##6 op_done_reg
    && pc == $past(op_imm, 6) && sp == $past(sp, 6) - 8'h04) else $error("far call result");
  a_ret_adds_four: assert property (g && op_code == `CBSC_OP_RET |-> ##6 op_done_reg && sp == $past(sp, 6) + 8'h04)
    else $error("return stack pointer");
  a_interrupt_return_op_adds_six: assert property (g && op_code == `CBSC_OP_INTERRUPT_RETURN_OP |-> ##8 op_done_reg && sp == $past(sp, 8) + 8'h06)
    else $error("interrupt return stack pointer");
endmodule
bind cbsc_exec cbsc_checker u_chk (.clk(clk), .rst_b(rst_b), .op_valid(op_valid), .op_ready(op_ready),
  .op_code(op_code), .op_imm(op_imm), .op_len(op_len), .op_done_reg(op_done_reg), .op_fault_reg(op_fault_reg),
  .pc(pc), .sp(sp), .master_irq_enable(master_irq_enable), .proc_clock_ctrl(proc_clock_ctrl),
  .mem_addr(mem_addr), .mem_we(mem_we));

// file: bench/cbsc_mem_model.sv
// 256 x 4 data memory holding the stack, one cycle read latency
// assumes strobes from the execute unit; the bench may preset words
module cbsc_mem_model (
  input wire clk,
  input wire [7:0] mem_addr,
  input wire [3:0] mem_wdata,
  input wire mem_we,
  input wire mem_re,
  output logic [3:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] mem [0:255];
  initial mem_rdata = 4'h5;
  always @(posedge clk)
  begin
    if (mem_we)
      mem[mem_addr] <= mem_wdata;
    // no read issued: toggle so stale data is never mistaken for an answer
    mem_rdata <= mem_re ? mem[mem_addr] : ~mem_rdata;
  end
endmodule

// file: bench/testbench.sv
// self-checking bench for the execute unit with a stack memory model
// assumes cbsc_exec, cbsc_mem_model and the bound checker
`include "cbsc_defs.vh"
module testbench;
  timeunit 1ns;
  // finer precision so the 12.5 ns half period is not rounded
  timeprecision 100ps;
  logic clk = 0, rst_b = 0, op_valid = 0, clock_wake = 0, f = 0, c = 0;
  logic [4:0] op_code = 0, o;
  logic [10:0] op_imm = 0, p = 0, r;
  logic [1:0] op_len = 1, bit_sel = 0;
  logic [7:0] bit_addr = 8'h40, s = 0;
  logic [27:0] pins = 0, eo = 0, v;
  logic [6:0] mode = 0;
  logic [3:0] a;
  logic [50:0] m, q [$];
  wire op_ready, op_done_reg, op_fault_reg, carry_flag, master_irq_enable, mem_we, mem_re;
  wire [10:0] pc;
  wire [7:0] sp, program_status_word, mem_addr;
  wire [3:0] acc_a, acc_x, ptr_h, ptr_l, source_irq_enable, proc_clock_ctrl, mem_wdata, mem_rdata;
  wire [27:0] port_out;
  int mismatches = 0, compares = 0, off[8] = '{-15, -1, 2, 16, -16, 0, 1, 17};
  cbsc_exec dut (.clk, .rst_b, .op_valid, .op_ready, .op_code, .op_imm, .op_len, .bit_addr, .bit_sel,
    .op_done_reg, .op_fault_reg, .pc, .sp, .acc_a, .acc_x, .ptr_h, .ptr_l, .program_status_word,
    .carry_flag, .master_irq_enable, .source_irq_enable, .proc_clock_ctrl, .clock_wake, .mem_addr,
    .mem_wdata, .mem_we, .mem_re, .mem_rdata, .port_pin_in(pins), .port_out_mode(mode), .port_out);
  cbsc_mem_model u_mem (.clk, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata);
  always #12.5 clk = ~clk;
  task close_out;
    begin
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input string n, input [27:0] e, input [27:0] g);
    begin
      compares++;
      if (g !== e)
      begin
        mismatches++;
        $display("[ERR] %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  // t < 0: pc just advances by the op length
  task go(input [4:0] op, input [10:0] i, input int t, input [2:0] sl, input [27:0] e);
    int n;
    begin
      p = t < 0 ? p + 11'(op_len) : 11'(t);
      q.push_back({p, s, f, sl, e});
      op_code = op;
      op_imm = i;
      op_valid = 1;
      @(posedge clk);
      #1 op_valid = 0;
      n = 0;
      while (op_done_reg !== 1'b1 && n < 12)
      begin
        @(posedge clk);
        #1 n++;
      end
      @(posedge clk);
      #1 f = 0;
      op_len = 2'($urandom_range(1, 2));
    end
  endtask
  always @(posedge clk)
    if (op_done_reg === 1'b1)
    begin
      m = q.pop_front();
      chk("pc", m[50:40], pc);
      chk("sp", m[39:32], sp);
      chk("fault", m[31], op_fault_reg);
      case (m[30:28])
        1: chk("carry", m[27:0], carry_flag);
        2: chk("acc", m[27:0], acc_a);
        3: chk("irq", m[27:0], {master_irq_enable, source_irq_enable});
        4: chk("pcc", m[27:0], proc_clock_ctrl);
        5: chk("pair", m[27:0], {ptr_h, ptr_l});
        7: chk("psw", m[27:0], program_status_word);
        default: ;
      endcase
    end
  initial
  begin
    #(25 * 4000);
    mismatches++;
    close_out;
  end
  initial
  begin
    void'($urandom(38));
    repeat (10) @(posedge clk);
    #1 rst_b = 1;
    go(`CBSC_OP_NOP, 0, -1, 0, 0);
    pins = $urandom;
    a = pins[3:0];
    repeat (6) @(posedge clk);
    #1 go(`CBSC_OP_IN, 0, -1, 2, a);
    for (int n = 0; n < 8; n++)
    begin
      f = !(n inside {2, 3, 5, 6});
      if (!f)
        eo[4*n +: 4] = a;
      go(`CBSC_OP_OUT, n, -1, 0, 0);
      chk("port_out", eo, port_out);
    end
    mode = $urandom;
    pins = $urandom;
    repeat (6) @(posedge clk);
    #1;
    for (int n = 0; n < 8; n++)
    begin
      f = n == 4 || n == 7;
      v = pins;
      if (n inside {2, 3, 5, 6} && mode[n])
        v = eo;
      if (!f)
        a = v[4*n +: 4];
      go(`CBSC_OP_IN, n, -1, f ? 0 : 2, a);
    end
    s = s - 8'h02;
    go(`CBSC_OP_PUSH, 0, -1, 0, 0);
    chk("push", {4'h0, a}, {u_mem.mem[s + 8'h01], u_mem.mem[s]});
    u_mem.mem[s + 8'h01] = $urandom;
    v = {u_mem.mem[s + 8'h01], a};
    s = s + 8'h02;
    go(`CBSC_OP_POP, 1, -1, 5, v);
    go(`CBSC_OP_BLOCK_ABSOLUTE_BRANCH, 11'h77f, 'h77f, 0, 0);
    r = $urandom_range(0, 'h77f);
    go(`CBSC_OP_BLOCK_ABSOLUTE_BRANCH, r, r, 0, 0);
    f = 1;
    go(`CBSC_OP_BLOCK_ABSOLUTE_BRANCH, 11'h780, -1, 0, 0);
    go(`CBSC_OP_BLOCK_ABSOLUTE_BRANCH, 11'h400, 'h400, 0, 0);
    for (int k = 0; k < 8; k++)
    begin
      f = k > 3;
      go(`CBSC_OP_BRREL, off[k] & 'h3f, f ? -1 : int'(p) + off[k], 0, 0);
    end
    r = p + 11'(op_len);
    s = s - 8'h04;
    go(`CBSC_OP_FAR_CALL_OP, 11'h77f, 'h77f, 0, 0);
    chk("frame", {r[7:0], 5'h00, r[10:8]},
      {u_mem.mem[s + 8'h03], u_mem.mem[s + 8'h02], u_mem.mem[s + 8'h01], u_mem.mem[s]});
    s = s + 8'h04;
    go(`CBSC_OP_RET, 0, r, 0, 0);
    f = 1;
    go(`CBSC_OP_FAR_CALL_OP, 11'h780, -1, 0, 0);
    r = p + 11'(op_len);
    s = s - 8'h04;
    go(`CBSC_OP_FAR_CALL_OP, 11'h200, 'h200, 0, 0);
    s = s + 8'h04;
    go(`CBSC_OP_SKIPPING_RETURN_OP, 0, r, 0, 0);
    go(`CBSC_OP_EI, 0, -1, 3, 0);
    r = p + 11'(op_len);
    s = s - 8'h04;
    go(`CBSC_OP_FAR_CALL_OP, 11'h300, 'h300, 0, 0);
    v = $urandom;
    u_mem.mem[s + 8'h04] = v[3:0];
    u_mem.mem[s + 8'h05] = v[7:4];
    s = s + 8'h06;
    c = v[7];
    go(`CBSC_OP_INTERRUPT_RETURN_OP, 0, r, 7, v[7:0]);
    repeat (8)
    begin
      bit_sel = $urandom;
      u_mem.mem[8'h40] = $urandom;
      o = 5'($urandom_range(1, 2));
      c = o == `CBSC_OP_OR1 ? c | u_mem.mem[8'h40][bit_sel] : c ^ u_mem.mem[8'h40][bit_sel];
      go(o, 0, -1, 1, c);
    end
    v = 0;
    for (int k = 0; k < 16; k++)
    begin
      o = `CBSC_OP_EI + 5'(k % 4);
      r = $urandom_range(0, 3);
      if (o == `CBSC_OP_EI || o == `CBSC_OP_DI)
        v[4] = o == `CBSC_OP_EI;
      else
        v[r] = o == `CBSC_OP_EISRC;
      go(o, r, -1, 3, v);
    end
    go(`CBSC_OP_HALT, 0, -1, 4, 4'h4);
    go(`CBSC_OP_BLOCK_ABSOLUTE_BRANCH, 11'h100, -1, 4, 4'h4);
    clock_wake = 1;
    go(`CBSC_OP_STOP, 0, -1, 4, 4'h8);
    clock_wake = 0;
    go(`CBSC_OP_IN, 0, -1, 2, a);
    close_out;
  end
endmodule
